// File: tsp_pkg.sv
/*
  Shared constants and helper functions for the temperature sensor serial port.
  Assumes a 200 MHz system clock and a host-driven serial clock.
*/
package tsp_pkg;

  // System clock and conversion timing.
  localparam int CLK_PERIOD_NS    = 5;
  localparam int CONV_TIME_MS     = 228;
  localparam int CONV_CYCLES      = CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;

  // Frame layout in serial clocks.
  localparam int FRAME_BITS       = 32;
  localparam int PHASE_BITS       = 16;
  localparam int CMD_BITS         = 8;
  localparam logic [4:0] IDX_FIRST    = 5'h00;
  localparam logic [4:0] IDX_CMD_FULL = 5'h17;
  localparam logic [4:0] IDX_LAST     = 5'h1F;
  localparam int PHASE_POS        = 4;

  // Commands.
  localparam logic [7:0] CMD_SHUTDOWN = 8'hFF;
  localparam logic [7:0] CMD_CONVERT  = 8'h00;

  // Word formats.
  localparam int SAMPLE_BITS      = 14;
  localparam logic [1:0] TAIL_BITS    = 2'h3;
  // Identification word: the value is arbitrary.
  localparam logic [15:0] ID_WORD     = 16'h2A57;

  // Reset values.
  localparam logic       RST_SHUTDOWN = 1'h0;
  localparam logic [4:0] RST_IDX      = 5'h00;
  localparam logic [7:0] RST_CMD      = 8'h00;

  function automatic logic [4:0] bin2gray(input logic [4:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [4:0] gray2bin(input logic [4:0] g);
    logic [4:0] b;
    b = 5'h00;
    b[4] = g[4];
    for (int i = 3; i >= 0; i--) begin
      b[i] = b[i + 1] ^ g[i];
    end
    return b;
  endfunction

endpackage

// File: tsp_conv_engine.sv
/*
  Periodic conversion engine: raises a one-cycle result strobe with a sample.
  Assumes the sample input is quasi-static; it may come from another clock domain and is synchronised in two stages.
*/
`timescale 1ns/1ps
`default_nettype none

module tsp_conv_engine #(
  parameter int PERIOD = tsp_pkg::CONV_CYCLES
) (
  // Clock and reset
  input  wire logic                              i_clk,
  input  wire logic                              i_rst_n,
  // Control and sample
  input  wire logic                              i_run,
  input  wire logic [tsp_pkg::SAMPLE_BITS-1:0]   i_sample,
  // Result
  output logic                                   o_ready,
  output logic [tsp_pkg::SAMPLE_BITS-1:0]        o_sample
);

  typedef struct packed {
    logic [31:0]                      count;
    logic [tsp_pkg::SAMPLE_BITS-1:0]  samp_meta;
    logic [tsp_pkg::SAMPLE_BITS-1:0]  samp_sync;
    logic                             ready;
    logic [tsp_pkg::SAMPLE_BITS-1:0]  sample;
  } tsp_conv_t;

  localparam logic [31:0] LAST = 32'(PERIOD - 1);

  tsp_conv_t st;
  tsp_conv_t next_st;

  ////////////////////////////////////////////////////////////////////////////////

  // A stopped engine restarts from zero, so the first result after run rises
  // always takes a full period.
  always_comb begin
    next_st = st;
    next_st.ready = 1'h0;
    // The sample comes from the sensing front end, so it is taken through two stages.
    next_st.samp_meta = i_sample;
    next_st.samp_sync = st.samp_meta;
    if (!i_run) begin
      next_st.count = 32'h0;
    end else if (st.count >= LAST) begin
      next_st.count  = 32'h0;
      next_st.ready  = 1'h1;
      next_st.sample = st.samp_sync;
    end else begin
      next_st.count = st.count + 32'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ready  = st.ready;
  assign o_sample = st.sample;

endmodule

`default_nettype wire

// File: tsp_serial_port.sv
/*
  Three-wire serial slave port and mode control of a temperature sensor.
  Assumes the host idles the serial clock low while chip select is high and
  drives command bits only after the device has released the data pin.
*/
`timescale 1ns/1ps
`default_nettype none

module tsp_serial_port #(
  parameter int CONV_PERIOD = tsp_pkg::CONV_CYCLES
) (
  // System clock and reset
  input  wire logic                             i_clk,
  input  wire logic                             i_rst_n,
  // Serial link from the host
  input  wire logic                             i_serial_clock,
  input  wire logic                             i_cs_n,
  input  wire logic                             i_sio_in,
  output logic                                  o_sio_out,
  output logic                                  o_sio_oe,
  // Sensing front end
  input  wire logic [tsp_pkg::SAMPLE_BITS-1:0]  i_temp_sample,
  // Status
  output logic                                  o_shutdown,
  output logic                                  o_data_valid
);

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain, rising edge: receive shifter and command hand-off.

  typedef struct packed {
    logic [7:0] cmd;
    logic       rx_full;
    logic       cmd_toggle;
  } tsp_rx_t;

  logic [4:0] rise_idx;
  tsp_rx_t    rx;
  tsp_rx_t    next_rx;

  // The counter is cleared by the select pin itself, so every low interval
  // starts at bit zero however the previous one ended.
  always_ff @(posedge i_serial_clock or negedge i_rst_n or posedge i_cs_n) begin
    if (!i_rst_n || i_cs_n) begin
      rise_idx <= tsp_pkg::RST_IDX;
    end else begin
      rise_idx <= rise_idx + 5'h01;
    end
  end

  always_comb begin
    next_rx = rx;
    if (rise_idx == tsp_pkg::IDX_FIRST) begin
      next_rx.rx_full = 1'h0;
    end
    if (rise_idx[tsp_pkg::PHASE_POS]) begin
      next_rx.cmd = {rx.cmd[6:0], i_sio_in};
    end
    if (rise_idx == tsp_pkg::IDX_CMD_FULL) begin
      next_rx.rx_full = 1'h1;
    end
    if (rise_idx == tsp_pkg::IDX_LAST) begin
      next_rx.cmd_toggle = ~rx.cmd_toggle;
    end
  end

  // These flops survive the end of a frame so the system side can read the
  // command after select has gone high.
  always_ff @(posedge i_serial_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain, falling edge: transmit bit index, gray coded for crossing.

  logic [4:0] fall_idx;
  logic [4:0] fall_gray;

  always_ff @(negedge i_serial_clock or negedge i_rst_n or posedge i_cs_n) begin
    if (!i_rst_n || i_cs_n) begin
      fall_idx  <= tsp_pkg::RST_IDX;
      fall_gray <= tsp_pkg::RST_IDX;
    end else begin
      fall_idx  <= fall_idx + 5'h01;
      fall_gray <= tsp_pkg::bin2gray(fall_idx + 5'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Conversion engine.

  logic                            conv_ready;
  logic [tsp_pkg::SAMPLE_BITS-1:0] conv_sample;

  tsp_conv_engine #(
    .PERIOD (CONV_PERIOD)
  ) u_conv (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_run    (~o_shutdown),
    .i_sample (i_temp_sample),
    .o_ready  (conv_ready),
    .o_sample (conv_sample)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // System domain: synchronisers, mode, output word and pin drive.

  typedef struct packed {
    logic                             cs_meta;
    logic                             cs_sync;
    logic                             cs_prev;
    logic [4:0]                       idx_meta;
    logic [4:0]                       idx_sync;
    logic                             full_meta;
    logic                             full_sync;
    logic                             tog_meta;
    logic                             tog_sync;
    logic                             tog_prev;
    logic                             shutdown;
    logic                             valid;
    logic                             pending;
    logic [tsp_pkg::SAMPLE_BITS-1:0]  result;
    logic [15:0]                      temp_word;
    logic                             sio_out;
    logic                             sio_oe;
  } tsp_sys_t;

  tsp_sys_t st;
  tsp_sys_t next_st;

  always_comb begin
    logic [4:0] idx;
    logic       apply;
    logic [7:0] cmd;
    logic [15:0] word;
    idx   = 5'h00;
    apply = 1'h0;
    cmd   = 8'h00;
    word  = 16'h0000;
    next_st = st;

    // Two-flop synchronisers; only the second stage is read below.
    next_st.cs_meta   = i_cs_n;
    next_st.cs_sync   = st.cs_meta;
    next_st.cs_prev   = st.cs_sync;
    next_st.idx_meta  = fall_gray;
    next_st.idx_sync  = st.idx_meta;
    next_st.full_meta = rx.rx_full;
    next_st.full_sync = st.full_meta;
    next_st.tog_meta  = rx.cmd_toggle;
    next_st.tog_sync  = st.tog_meta;
    next_st.tog_prev  = st.tog_sync;

    // A command is taken at the end of a full receive phase, or at deselect
    // once at least eight bits came in. The shifter is idle at both moments.
    if (st.tog_sync != st.tog_prev) begin
      apply = 1'h1;
    end
    if (st.cs_sync && !st.cs_prev && st.full_sync) begin
      apply = 1'h1;
    end
    cmd = rx.cmd;
    if (apply) begin
      if (cmd == tsp_pkg::CMD_SHUTDOWN) begin
        next_st.shutdown = 1'h1;
      end else if (cmd == tsp_pkg::CMD_CONVERT) begin
        if (st.shutdown) begin
          next_st.valid   = 1'h0;
          next_st.pending = 1'h0;
        end
        next_st.shutdown = 1'h0;
      end
      // Other codes are left without effect rather than guessing a test mode.
    end

    // Results are held until the host is not reading.
    if (conv_ready) begin
      next_st.result  = conv_sample;
      next_st.pending = 1'h1;
      next_st.valid   = 1'h1;
    end
    if (st.cs_sync && st.pending && !conv_ready) begin
      next_st.temp_word = {st.result, tsp_pkg::TAIL_BITS};
      next_st.pending   = 1'h0;
    end

    // Pin drive: word bit chosen by the falling-edge count, MSB first.
    idx  = tsp_pkg::gray2bin(st.idx_sync);
    word = st.shutdown ? tsp_pkg::ID_WORD : st.temp_word;
    if (st.cs_sync) begin
      next_st.sio_oe  = 1'h0;
      next_st.sio_out = word[15];
    end else begin
      next_st.sio_oe  = ~idx[tsp_pkg::PHASE_POS];
      next_st.sio_out = word[4'hF - idx[3:0]];
    end
  end

  // The output enable lags select by the synchroniser depth, a few system
  // clocks, which is far inside one serial clock period.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
      st.cs_meta  <= 1'h1;
      st.cs_sync  <= 1'h1;
      st.cs_prev  <= 1'h1;
      st.shutdown <= tsp_pkg::RST_SHUTDOWN;
    end else begin
      st <= next_st;
    end
  end

  assign o_sio_out    = st.sio_out;
  assign o_sio_oe     = st.sio_oe;
  assign o_shutdown   = st.shutdown;
  assign o_data_valid = st.valid;

endmodule

`default_nettype wire

// File: tsp_serial_port_assertions.sv
/*
  Checker for the temperature sensor serial port, bound into the top module.
  Assumes the host idles the serial clock low and leaves select high between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module tsp_chk (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Link and status
  input  wire logic i_cs_n,
  input  wire logic o_sio_out,
  input  wire logic o_sio_oe,
  input  wire logic o_shutdown,
  input  wire logic o_data_valid
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Select is synchronised, so the pin follows it a few cycles late.
  sequence s_desel;
    i_cs_n [*6];
  endsequence
  sequence s_quiet;
    !o_data_valid [*8];
  endsequence

  AST_RST_MODE: assert property ($rose(i_rst_n) |-> !o_shutdown && !o_sio_oe)
    else $error("mode or pin wrong after reset");
  AST_HIZ: assert property (s_desel |-> !o_sio_oe)
    else $error("pin driven while deselected");
  AST_FIRST_BIT: assert property ($fell(i_cs_n) |-> ##[1:5] o_sio_oe)
    else $error("first bit not driven");
  AST_EARLY_END: assert property ($rose(i_cs_n) |-> ##[1:5] !o_sio_oe)
    else $error("pin kept after deselect");
  AST_RX_FREE: assert property ($fell(o_sio_oe) && !i_cs_n |=> !o_sio_oe [*8])
    else $error("pin driven in receive phase");
  AST_ID_BIT: assert property (o_shutdown && $rose(o_sio_oe) |-> o_sio_out == tsp_pkg::ID_WORD[15])
    else $error("shutdown word wrong");
  AST_MODE_QUIET: assert property ($changed(o_shutdown) |-> !o_sio_oe)
    else $error("mode changed during transmit");
  AST_RESUME: assert property ($fell(o_shutdown) |-> ##[0:1] s_quiet)
    else $error("valid too early after resume");
  AST_VALID_MODE: assert property ($rose(o_data_valid) |-> !o_shutdown)
    else $error("result in shutdown");
endmodule

bind tsp_serial_port tsp_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n),
  .o_sio_out(o_sio_out), .o_sio_oe(o_sio_oe), .o_shutdown(o_shutdown),
  .o_data_valid(o_data_valid));

`default_nettype wire

// File: tsp_host.sv
/*
  Host model: serial master that frames transfers and resolves the data wire.
  Assumes the device output and enable are its inputs; 80 ns serial clock.
*/
`timescale 1ns/1ps
`default_nettype none

module tsp_host (
  // Device pin side
  input  wire logic i_sio_out,
  input  wire logic i_sio_oe,
  // Host side of the link
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_sio
);
  logic drv;
  logic bitv;
  logic flt;

  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    drv = 1'b0;
    bitv = 1'b0;
    flt = 1'b0;
  end
  // No pull on the wire, so a released pin shows a changing level.
  always @(posedge o_sck) flt <= ~flt;
  assign o_sio = i_sio_oe ? i_sio_out : (drv ? bitv : flt);

  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input int n, input logic [31:0] wr, output logic [31:0] rd);
    int s;
    int w;
    rd = 32'h0;
    o_cs_n = 1'b0;
    #60;
    for (int k = 0; k < n; k++) begin
      s = (k / 32) * 16;
      w = k % 32;
      #20;
      drv = (w >= 16);
      if (w >= 16) bitv = wr[31 - s - (w - 16)];
      #20;
      o_sck = 1'b1;
      if (w < 16) rd[31 - s - w] = o_sio;
      #40;
      o_sck = 1'b0;
    end
    #20;
    drv = 1'b0;
    o_cs_n = 1'b1;
    #200;
  endtask
endmodule

`default_nettype wire

// File: temp_sensor_serial_port_tb.sv
/*
  Self-checking bench of the serial port with a host model on the link.
  Assumes a shortened conversion period; expectations follow from it.
*/
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_serial_port_tb;
  localparam int PER = 200;
  typedef struct packed { logic [13:0] smp; logic [15:0] word; } tsp_row_t;
  logic        i_clk;
  logic        i_rst_n;
  logic [13:0] i_temp_sample;
  wire         sck;
  wire         cs_n;
  wire         sio;
  logic        o_sio_out;
  logic        o_sio_oe;
  logic        o_shutdown;
  logic        o_data_valid;
  logic [31:0] rd;
  int          mismatches;
  int          n_tests;
  tsp_row_t    rows [5] = '{'{14'h0320, 16'h0C83}, '{14'h3FFF, 16'hFFFF},
    '{14'h0000, 16'h0003}, '{14'h12C0, 16'h4B03}, '{14'h3B00, 16'hEC03}};

  always #2.5 i_clk = ~i_clk;

  tsp_serial_port #(.CONV_PERIOD(PER)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_serial_clock(sck), .i_cs_n(cs_n), .i_sio_in(sio), .o_sio_out(o_sio_out),
    .o_sio_oe(o_sio_oe), .i_temp_sample(i_temp_sample), .o_shutdown(o_shutdown),
    .o_data_valid(o_data_valid));
  tsp_host u_host (.i_sio_out(o_sio_out), .i_sio_oe(o_sio_oe), .o_sck(sck),
    .o_cs_n(cs_n), .o_sio(sio));

  ////////////////////////////////////////////////////////////////////////////
  task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_flag(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task summarize;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    i_temp_sample = 14'h0000;
    mismatches = 0;
    n_tests = 0;
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc(2);
    chk_flag("shutdown", 1'b0, o_shutdown);
    chk_flag("valid", 1'b0, o_data_valid);
    u_host.xfer(16, 32'h0, rd);
    foreach (rows[i]) begin
      @(posedge i_clk);
      i_temp_sample <= rows[i].smp;
      cyc(2 * PER + 10);
      u_host.xfer(16, 32'h0, rd);
      chk_word("temp", rows[i].word, rd[31:16]);
      chk_flag("valid", 1'b1, o_data_valid);
      $display("row %0d done", i);
    end
    u_host.xfer(5, 32'h0, rd);
    u_host.xfer(16, 32'h0, rd);
    chk_word("after abort", rows[4].word, rd[31:16]);
    u_host.xfer(64, {16'h00FF, 16'h0000}, rd);
    chk_word("chain temp", rows[4].word, rd[31:16]);
    chk_word("chain id", tsp_pkg::ID_WORD, rd[15:0]);
    chk_flag("resume mode", 1'b0, o_shutdown);
    chk_flag("resume valid", 1'b0, o_data_valid);
    cyc(PER + 20);
    chk_flag("resume valid", 1'b1, o_data_valid);
    $display("chained frame done");
    u_host.xfer(32, {16'hFF00, 16'h0}, rd);
    chk_flag("low byte", 1'b0, o_shutdown);
    u_host.xfer(24, {16'hFF00, 16'h0}, rd);
    chk_flag("eight bits", 1'b1, o_shutdown);
    u_host.xfer(32, {16'hFFFF, 16'h0}, rd);
    chk_word("id", tsp_pkg::ID_WORD, rd[31:16]);
    chk_flag("repeat shutdown", 1'b1, o_shutdown);
    $display("shutdown done");
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    cyc(16);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    cyc(3);
    chk_flag("rerun mode", 1'b0, o_shutdown);
    $display("reset done");
    summarize;
  end

  // About five and a half times the expected run length, so a hang cannot end silently.
  initial begin
    #200000;
    mismatches++;
    summarize;
  end
endmodule

`default_nettype wire
